// *** rtl/ass_top.sv ***
// Purpose: alarm history and stop sequencer for a multi-axis drive
// Assumes: APB slave, alarms arrive as one-cycle pulses
// Notes: history record is alarm number word plus power-on seconds word
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/10ps
module ass_top
   import ass_pkg::*;
#(
   parameter int NAX = 2,
   parameter int DEPTH = 16,
   parameter int SPW = 16,
   parameter int TICKS_PER_SEC = 250000000
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Alarm source
   input wire logic alarm_valid,
   input wire logic [31:0] alarm_number,
   input wire logic [1:0] alarm_method,
   input wire logic alarm_all_axes,
   input wire logic [NAX-1:0] alarm_axis,
   input wire logic alarm_reset,
   input wire logic netloss,
   input wire logic tool_clear,
   input wire logic transient_clear,
   // Motor
   input wire logic [NAX-1:0] edb_motor,
   input wire logic [2:0] ctrl_mode,
   input wire logic [NAX*SPW-1:0] cmd_speed,
   input wire logic [NAX*SPW-1:0] act_speed,
   // Drive outputs
   output logic [NAX*SPW-1:0] speed_ref,
   output logic [NAX-1:0] base_on,
   output logic [NAX-1:0] dbrake_on,
   output logic [NAX-1:0] edbrake_on,
   output logic [NAX-1:0] brake_interlock_out,
   output logic [NAX-1:0] fault_output,
   output logic [NAX-1:0] cmd_accept,
   output logic coord_out
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [31:0] ctrl;
      logic [15:0] zspeed;
      logic [15:0] decstep;
      logic [AW:0] count;
      logic [AW-1:0] head;
      logic [31:0] tick;
      logic [31:0] secs;
      logic [31:0] rdata;
      logic ready;
   } ass_top_t;
   ass_top_t s_q, s_d;
   logic [31:0] hist_num [DEPTH];
   logic [31:0] hist_time [DEPTH];

   logic apb_setup;
   logic apb_wr;
   logic hist_clear;
   logic [NAX-1:0] stop_req;
   logic [NAX-1:0] stopped;
   logic decel_en;
   logic [AW-1:0] rd_idx;
   logic [AW-1:0] rd_slot;
   logic rd_hist;

   // ********************************************************************
   // Bus decode
   // ********************************************************************
   // Zero-wait access for every register, the history read included
   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pwrite && s_q.ready;
   assign pready = s_q.ready;
   assign pslverr = 1'b0;
   assign prdata = s_q.rdata;
   assign rd_hist = (paddr >= ADDR_HIST) && (paddr <= ADDR_HIST_END);
   assign rd_idx = AW'((paddr - ADDR_HIST) >> 3);
   // Index 0 is the newest record
   assign rd_slot = s_q.head - AW'(1) - rd_idx;

   // Deceleration enabled only with select value 2
   assign decel_en = (s_q.ctrl[CTRL_DECEL_LSB +: 4] == DECEL_ON); // RL9

   // History clear sources
   assign hist_clear = (s_q.ctrl[CTRL_HCLR_NET] || s_q.ctrl[CTRL_HCLR_PULSE]
      || tool_clear || transient_clear
      || (apb_wr && paddr == ADDR_HCLEAR
          && pwdata[15:0] == HCLEAR_KEY)); // RL4

   // ********************************************************************
   // Register and timer next state
   // ********************************************************************
   always_comb begin
      s_d = s_q;
      // Power-on time base in seconds
      if (s_q.tick == 32'(TICKS_PER_SEC - 1)) begin
         s_d.tick = '0;
         s_d.secs = s_q.secs + 32'h1;
      end else begin
         s_d.tick = s_q.tick + 32'h1;
      end
      // Ready rises in the cycle after setup
      s_d.ready = apb_setup;
      if (apb_setup && !pwrite) begin
         if (rd_hist) begin
            if (AW'(rd_idx) < s_q.count[AW-1:0] || s_q.count[AW]) begin
               s_d.rdata = paddr[2] ? hist_time[rd_slot]
                  : hist_num[rd_slot]; // RL1 RL3
            end else begin
               s_d.rdata = '0;
            end
         end else begin
            case (paddr)
               ADDR_CTRL: s_d.rdata = s_q.ctrl;
               ADDR_STATUS: s_d.rdata = 32'({stopped, decel_en});
               ADDR_ZSPEED: s_d.rdata = 32'(s_q.zspeed);
               ADDR_DECSTEP: s_d.rdata = 32'(s_q.decstep);
               ADDR_HCOUNT: s_d.rdata = 32'(s_q.count);
               default: s_d.rdata = '0;
            endcase
         end
      end
      // Clear selections act once then self-clear; a same-cycle write wins
      if (s_q.ctrl[CTRL_HCLR_NET] || s_q.ctrl[CTRL_HCLR_PULSE]) begin
         s_d.ctrl[CTRL_HCLR_NET] = 1'b0;
         s_d.ctrl[CTRL_HCLR_PULSE] = 1'b0;
      end
      if (apb_wr) begin
         case (paddr)
            ADDR_CTRL: s_d.ctrl = pwdata;
            ADDR_ZSPEED: s_d.zspeed = pwdata[15:0];
            ADDR_DECSTEP: s_d.decstep = pwdata[15:0];
            default: s_d.ctrl = s_d.ctrl;
         endcase
      end
      // History pointers: a new alarm wins over a clear
      if (alarm_valid) begin
         s_d.head = s_q.head + AW'(1);
         if (hist_clear) begin
            s_d.head = s_q.head + AW'(1);
            s_d.count = (AW+1)'(1);
         end else if (s_q.count != (AW+1)'(DEPTH)) begin
            s_d.count = s_q.count + (AW+1)'(1); // RL2
         end
      end else if (hist_clear) begin
         s_d.count = '0; // RL4
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{ctrl: CTRL_RESET, zspeed: ZSPEED_RESET,
            decstep: DECSTEP_RESET, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // ********************************************************************
   // History memory
   // ********************************************************************
   // Ring store, oldest slot overwritten when full
   always_ff @(posedge pclk) begin
      if (alarm_valid) begin
         hist_num[s_q.head] <= alarm_number; // RL2 RL3
         hist_time[s_q.head] <= s_q.secs; // RL3
      end
   end

   // ********************************************************************
   // Axis stop routing
   // ********************************************************************
   // All-axis alarms, or a braking network loss, stop every axis
   always_comb begin
      stop_req = '0;
      if (alarm_valid) begin
         stop_req = alarm_all_axes ? '1 : alarm_axis; // RL19 RL20
      end
      if (netloss && s_q.ctrl[CTRL_NETLOSS_DB]) begin
         stop_req = '1; // RL18
      end
   end

   assign coord_out = s_q.ctrl[CTRL_COORD] && (stopped == '1); // RL21

   genvar g;
   generate
      for (g = 0; g < NAX; g++) begin : gen_ax
         ass_axis #(
            .SPW(SPW)
         ) u_ax (
            .pclk(pclk),
            .presetn(presetn),
            .stop_req(stop_req[g]),
            .stop_method((netloss && s_q.ctrl[CTRL_NETLOSS_DB])
               ? 2'(ASS_METH_DBRAKE) : alarm_method),
            .alarm_reset(alarm_reset),
            .decel_en(decel_en),
            .db_fitted(s_q.ctrl[CTRL_DB_FITTED]),
            .edb_motor(edb_motor[g]),
            .ctrl_mode(ctrl_mode),
            .zero_speed(SPW'(s_q.zspeed)),
            .decel_step(SPW'(s_q.decstep)),
            .cmd_speed(cmd_speed[g*SPW +: SPW]),
            .act_speed(act_speed[g*SPW +: SPW]),
            .speed_ref(speed_ref[g*SPW +: SPW]),
            .base_on(base_on[g]),
            .dbrake_on(dbrake_on[g]),
            .edbrake_on(edbrake_on[g]),
            .brake_interlock_out(brake_interlock_out[g]),
            .fault_output(fault_output[g]),
            .stopped(stopped[g])
         );
         // Cyclic synchronous commands refused while stopped
         assign cmd_accept[g] = !(stopped[g]
            && ctrl_mode == MODE_CYC_SYNC); // RL12 RL13
      end
   endgenerate

   // ********************************************************************
   // Checks
   // ********************************************************************
   property p_hist_cap;
      @(posedge pclk) disable iff (!presetn)
      s_q.count <= (AW+1)'(DEPTH);
   endproperty
   a_hist_cap: assert property (p_hist_cap) // RL1
      else $error("history over depth");
   property p_hist_full;
      @(posedge pclk) disable iff (!presetn)
      (alarm_valid && !hist_clear && s_q.count == (AW+1)'(DEPTH))
         |=> s_q.count == (AW+1)'(DEPTH);
   endproperty
   a_hist_full: assert property (p_hist_full) // RL2
      else $error("full history count changed");
   property p_hist_clr;
      @(posedge pclk) disable iff (!presetn)
      (hist_clear && !alarm_valid) |=> s_q.count == '0;
   endproperty
   a_hist_clr: assert property (p_hist_clr) // RL4
      else $error("history not cleared");
   property p_all_axes;
      @(posedge pclk) disable iff (!presetn)
      (alarm_valid && alarm_all_axes) |=> (stopped == '1);
   endproperty
   a_all_axes: assert property (p_all_axes) // RL20
      else $error("all-axis alarm missed an axis");
   property p_cyc_block;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_mode == MODE_CYC_SYNC && alarm_valid && alarm_all_axes)
         |=> (ctrl_mode != MODE_CYC_SYNC) || !cmd_accept[0];
   endproperty
   a_cyc_block: assert property (p_cyc_block) // RL12
      else $error("command accepted while stopped");
endmodule

// *** rtl/ass_pkg.sv ***
// Purpose: constants and types for the alarm stop sequencer
// Assumes: one clock pclk at 250 MHz, APB register access
// Notes: register offsets are byte addresses on 32-bit words
//
// Behaviour
// RL1 - History keeps the sixteen newest alarm records readable.
// RL2 - A new alarm into a full history drops the oldest record.
// RL3 - Each record holds alarm number and powered-on time at the alarm.
// RL4 - History empties on clear setting, tool or transient command.
// RL5 - Every alarm maps to one of three stop methods.
// RL6 - Forced deceleration ramps down first, then applies dynamic brake.
// RL7 - Dynamic brake method brakes at once; without brake the motor coasts.
// RL8 - Electronic brake only for qualifying motors, else dynamic brake.
// RL9 - Deceleration select 2 enables ramp, 0 disables it and brakes.
// RL10 - Configurer should disable ramp stop on mechanically coupled axes.
// RL11 - Torque, torque-continuous and pressure modes never ramp on alarm.
// RL12 - In cyclic synchronous mode, commands are ignored while stopped.
// RL13 - Controller must re-establish position command before resuming.
// RL14 - Ramp stop drops brake interlock and fault outputs on alarm.
// RL15 - During ramp the speed reference is internal, falling to zero.
// RL16 - Cut energy and brake when reference is zero and speed is low.
// RL17 - Brake stop drops interlock and fault at once, then brakes.
// RL18 - Lost network communication may engage the dynamic brake.
// RL19 - Own-axis alarm stops only that axis; others keep running.
// RL20 - All-axis alarm puts every axis into the stop sequence.
// RL21 - Shared converter needs multi-unit coordination select set to 1.
package ass_pkg;
   // ********************************************************************
   // Register map
   // ********************************************************************
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_ZSPEED = 12'h008;
   localparam logic [11:0] ADDR_DECSTEP = 12'h00C;
   localparam logic [11:0] ADDR_HCOUNT = 12'h010;
   localparam logic [11:0] ADDR_HCLEAR = 12'h014;
   localparam logic [11:0] ADDR_HIST = 12'h100;
   localparam logic [11:0] ADDR_HIST_END = 12'h17C;
   localparam logic [15:0] HCLEAR_KEY = 16'h1EA5;
   // Control register fields
   localparam int CTRL_DECEL_LSB = 0;
   localparam int CTRL_HCLR_NET = 4;
   localparam int CTRL_HCLR_PULSE = 5;
   localparam int CTRL_COORD = 6;
   localparam int CTRL_DB_FITTED = 7;
   localparam int CTRL_NETLOSS_DB = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0080;
   localparam logic [3:0] DECEL_ON = 4'h2;
   localparam logic [3:0] DECEL_OFF = 4'h0;
   localparam logic [15:0] ZSPEED_RESET = 16'h0032;
   localparam logic [15:0] DECSTEP_RESET = 16'h0001;
   // ********************************************************************
   // Modes and methods
   // ********************************************************************
   localparam logic [2:0] MODE_TORQUE = 3'h1;
   localparam logic [2:0] MODE_TQ_CONT = 3'h2;
   localparam logic [2:0] MODE_PRESSURE = 3'h3;
   localparam logic [2:0] MODE_CYC_SYNC = 3'h4;
   typedef enum logic [1:0] {
      ASS_METH_DECEL, ASS_METH_DBRAKE, ASS_METH_EDBRAKE
   } ass_method_t;
   typedef enum logic [2:0] {
      ASS_RUN, ASS_RAMP, ASS_DBRAKE, ASS_EDBRAKE, ASS_COAST
   } ass_state_t;
endpackage

// *** rtl/ass_axis.sv ***
// Purpose: stop sequence of one axis
// Assumes: alarm request pulse, speeds as unsigned magnitudes
// Notes: stays stopped until the alarm reset pulse
`timescale 1ns/10ps
module ass_axis
   import ass_pkg::*;
#(
   parameter int SPW = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Alarm entry
   input wire logic stop_req,
   input wire logic [1:0] stop_method,
   input wire logic alarm_reset,
   // Configuration
   input wire logic decel_en,
   input wire logic db_fitted,
   input wire logic edb_motor,
   input wire logic [2:0] ctrl_mode,
   input wire logic [SPW-1:0] zero_speed,
   input wire logic [SPW-1:0] decel_step,
   // Motion
   input wire logic [SPW-1:0] cmd_speed,
   input wire logic [SPW-1:0] act_speed,
   // Outputs
   output logic [SPW-1:0] speed_ref,
   output logic base_on,
   output logic dbrake_on,
   output logic edbrake_on,
   output logic brake_interlock_out,
   output logic fault_output,
   output logic stopped
);
   typedef struct packed {
      ass_state_t st;
      logic [SPW-1:0] ref_v;
   } ass_ax_t;
   ass_ax_t s_q, s_d;

   // ********************************************************************
   // Stop sequencing
   // ********************************************************************
   // Choose the stop entry from method, mode and hardware
   function automatic ass_state_t pick(input logic [1:0] m);
      logic no_ramp;
      no_ramp = (ctrl_mode == MODE_TORQUE) || (ctrl_mode == MODE_TQ_CONT)
         || (ctrl_mode == MODE_PRESSURE); // RL11
      if (m == ASS_METH_DECEL && decel_en && !no_ramp) begin // RL6 RL9
         pick = ASS_RAMP;
      end else if (m == ASS_METH_EDBRAKE && edb_motor) begin // RL8
         pick = ASS_EDBRAKE;
      end else begin
         pick = db_fitted ? ASS_DBRAKE : ASS_COAST; // RL7
      end
   endfunction

   always_comb begin
      s_d = s_q;
      case (s_q.st)
         ASS_RUN: begin
            s_d.ref_v = cmd_speed;
            if (stop_req) begin
               s_d.st = pick(stop_method); // RL5 RL17
            end
         end
         ASS_RAMP: begin
            // Internal reference falls toward zero
            if (s_q.ref_v > decel_step) begin // RL15
               s_d.ref_v = s_q.ref_v - decel_step;
            end else begin
               s_d.ref_v = '0;
            end
            if (s_q.ref_v == '0 && act_speed <= zero_speed) begin // RL16
               s_d.st = db_fitted ? ASS_DBRAKE : ASS_COAST;
            end
         end
         ASS_DBRAKE, ASS_EDBRAKE, ASS_COAST: begin
            s_d.ref_v = '0;
            if (alarm_reset) begin
               s_d.st = ASS_RUN;
            end
         end
         default: s_d.st = ASS_RUN;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{st: ASS_RUN, ref_v: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs from state
   assign speed_ref = s_q.ref_v;
   assign base_on = (s_q.st == ASS_RUN) || (s_q.st == ASS_RAMP); // RL16
   assign dbrake_on = (s_q.st == ASS_DBRAKE);
   assign edbrake_on = (s_q.st == ASS_EDBRAKE);
   assign brake_interlock_out = (s_q.st == ASS_RUN); // RL14 RL17
   assign fault_output = (s_q.st == ASS_RUN); // RL14 RL17
   assign stopped = (s_q.st != ASS_RUN);

   // ********************************************************************
   // Checks
   // ********************************************************************
   property p_ramp_drop;
      @(posedge pclk) disable iff (!presetn)
      (s_q.st == ASS_RAMP) |-> !brake_interlock_out && !fault_output;
   endproperty
   a_ramp_drop: assert property (p_ramp_drop) // RL14
      else $error("outputs high during ramp");
   property p_ramp_falls;
      @(posedge pclk) disable iff (!presetn)
      (s_q.st == ASS_RAMP) ##1 (s_q.st == ASS_RAMP)
         |-> speed_ref <= $past(speed_ref);
   endproperty
   a_ramp_falls: assert property (p_ramp_falls) // RL15
      else $error("ramp reference rose");
   property p_brake_end;
      @(posedge pclk) disable iff (!presetn)
      (s_q.st == ASS_RAMP && speed_ref == '0 && act_speed <= zero_speed)
         |=> !base_on;
   endproperty
   a_brake_end: assert property (p_brake_end) // RL16
      else $error("energy not cut at standstill");
   property p_no_ramp_mode;
      @(posedge pclk) disable iff (!presetn)
      (s_q.st == ASS_RUN && stop_req && ctrl_mode == MODE_TORQUE)
         |=> s_q.st != ASS_RAMP;
   endproperty
   a_no_ramp_mode: assert property (p_no_ramp_mode) // RL11
      else $error("ramp in torque mode");
   property p_dbrake_now;
      @(posedge pclk) disable iff (!presetn)
      (s_q.st == ASS_RUN && stop_req && stop_method == ASS_METH_DBRAKE
         && db_fitted) |=> dbrake_on && !fault_output;
   endproperty
   a_dbrake_now: assert property (p_dbrake_now) // RL17
      else $error("brake stop not immediate");
   property p_edb_fallback;
      @(posedge pclk) disable iff (!presetn)
      (s_q.st == ASS_RUN && stop_req && stop_method == ASS_METH_EDBRAKE
         && !edb_motor) |=> !edbrake_on;
   endproperty
   a_edb_fallback: assert property (p_edb_fallback) // RL8
      else $error("electronic brake on other motor");
   property p_decel_off;
      @(posedge pclk) disable iff (!presetn)
      (s_q.st == ASS_RUN && stop_req && !decel_en) |=> s_q.st != ASS_RAMP;
   endproperty
   a_decel_off: assert property (p_decel_off) // RL9
      else $error("ramp with decel disabled");
   property p_coast;
      @(posedge pclk) disable iff (!presetn)
      (s_q.st == ASS_RUN && stop_req && stop_method == ASS_METH_DBRAKE
         && !db_fitted) |=> !dbrake_on && !base_on;
   endproperty
   a_coast: assert property (p_coast) // RL7
      else $error("no coast without brake");
endmodule

// *** tb/ass_ctrl_model.sv ***
// Purpose: motion controller and motor stand-in for the sequencer
// Assumes: one clock, speeds as unsigned magnitudes
// Notes: motor speed follows the drive reference one cycle late
`timescale 1ns/10ps
module ass_ctrl_model
#(
   parameter int NAX = 2,
   parameter int SPW = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Drive side
   input wire logic [NAX*SPW-1:0] speed_ref,
   input wire logic [NAX-1:0] cmd_accept,
   // Bench side
   input wire logic [SPW-1:0] set_speed,
   // Commands and feedback
   output logic [NAX*SPW-1:0] cmd_speed,
   output logic [NAX*SPW-1:0] act_speed
);
   // *****************
   // Command and plant
   // *****************
   // Refused commands drop to zero until the axis accepts again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_speed <= '0;
         act_speed <= '0;
      end else begin
         act_speed <= speed_ref;
         for (int i = 0; i < NAX; i++) begin
            cmd_speed[i*SPW +: SPW] <= cmd_accept[i] ? set_speed : '0;
         end
      end
   end
endmodule

// *** tb/test_ass_top.sv ***
// Purpose: self-checking bench for the alarm stop sequencer
// Assumes: two axes, seconds tick shortened to ten cycles
// Notes: registers over APB, alarms as single-cycle pulses
`timescale 1ns/10ps
module test_ass_top
   import ass_pkg::*;
   ;
   // *****************
   // Wiring
   // *****************
   localparam int NAX = 2;
   localparam int SPW = 16;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdat, t_new;
   logic pready, pslverr;
   logic alarm_valid = 1'b0;
   logic [31:0] alarm_number = 32'h0;
   logic [1:0] alarm_method = 2'h0;
   logic alarm_all_axes = 1'b0;
   logic [NAX-1:0] alarm_axis = 2'h0;
   logic alarm_reset = 1'b0;
   logic netloss = 1'b0;
   logic tool_clear = 1'b0;
   logic transient_clear = 1'b0;
   logic [NAX-1:0] edb_motor = 2'h0;
   logic [2:0] ctrl_mode = 3'h0;
   logic [SPW-1:0] set_speed = 16'h0;
   logic [NAX*SPW-1:0] cmd_speed, act_speed, speed_ref;
   logic [NAX-1:0] base_on, dbrake_on, edbrake_on, cmd_accept;
   logic [NAX-1:0] brake_interlock_out, fault_output;
   logic coord_out;
   int n_errors = 0;
   int checks = 0;

   ass_top #(.NAX(NAX), .DEPTH(16), .SPW(SPW), .TICKS_PER_SEC(10)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .alarm_valid(alarm_valid),
      .alarm_number(alarm_number), .alarm_method(alarm_method),
      .alarm_all_axes(alarm_all_axes), .alarm_axis(alarm_axis),
      .alarm_reset(alarm_reset), .netloss(netloss),
      .tool_clear(tool_clear), .transient_clear(transient_clear),
      .edb_motor(edb_motor), .ctrl_mode(ctrl_mode),
      .cmd_speed(cmd_speed), .act_speed(act_speed),
      .speed_ref(speed_ref), .base_on(base_on), .dbrake_on(dbrake_on),
      .edbrake_on(edbrake_on), .brake_interlock_out(brake_interlock_out),
      .fault_output(fault_output), .cmd_accept(cmd_accept),
      .coord_out(coord_out));

   ass_ctrl_model #(.NAX(NAX), .SPW(SPW)) i_ctrl (
      .pclk(pclk), .presetn(presetn), .speed_ref(speed_ref),
      .cmd_accept(cmd_accept), .set_speed(set_speed),
      .cmd_speed(cmd_speed), .act_speed(act_speed));

   // Clock
   initial begin
      forever #2 pclk = ~pclk;
   end

   // *****************
   // Shared tasks
   // *****************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask

   task automatic fire(input logic [1:0] m, input logic all,
                       input logic [1:0] ax, input logic [31:0] num);
      @(posedge pclk);
      alarm_valid <= 1'b1;
      alarm_method <= m;
      alarm_all_axes <= all;
      alarm_axis <= ax;
      alarm_number <= num;
      @(posedge pclk);
      alarm_valid <= 1'b0;
      wait_n(3);
   endtask

   task automatic rearm();
      @(posedge pclk);
      alarm_reset <= 1'b1;
      @(posedge pclk);
      alarm_reset <= 1'b0;
      wait_n(3);
   endtask

   // *****************
   // Scenarios
   // *****************
   task automatic s_regs();
      chk(base_on, 2'b11);
      chk(fault_output, 2'b11);
      rd(ADDR_CTRL, CTRL_RESET);
      rd(ADDR_ZSPEED, ZSPEED_RESET);
      rd(ADDR_DECSTEP, DECSTEP_RESET);
      apb(1'b1, 12'h020, 32'hFFFF);
      chk(pslverr, 1'b0);
      rd(12'h020, 32'h0);
   endtask

   task automatic s_ramp();
      apb(1'b1, ADDR_CTRL, 32'h82);
      apb(1'b1, ADDR_DECSTEP, 32'h10);
      set_speed <= 16'h100;
      wait_n(4);
      chk(speed_ref[15:0], 16'h100);
      fire(2'h0, 1'b0, 2'b01, 32'h11);
      chk(brake_interlock_out, 2'b10);
      chk(fault_output, 2'b10);
      chk({base_on, dbrake_on}, 4'b1100);
      chk(speed_ref[15:0] < 16'h100, 1'b1);
      for (int i = 0; i < 100 && dbrake_on[0] !== 1'b1; i++) wait_n(1);
      chk(speed_ref[15:0], 16'h0);
      chk({base_on, dbrake_on}, 4'b1001);
      chk(speed_ref[31:16], 16'h100);
      rd(ADDR_STATUS, 32'h3);
      rearm();
   endtask

   task automatic s_dbrake();
      apb(1'b1, ADDR_CTRL, 32'hC2);
      fire(2'h1, 1'b1, 2'b00, 32'h12);
      chk({base_on, dbrake_on}, 4'b0011);
      chk({brake_interlock_out, fault_output}, 4'h0);
      chk(coord_out, 1'b1);
      rearm();
      chk({coord_out, base_on}, 3'b011);
   endtask

   task automatic s_edb();
      apb(1'b1, ADDR_CTRL, 32'h82);
      edb_motor <= 2'b01;
      fire(2'h2, 1'b1, 2'b00, 32'h13);
      chk({edbrake_on, dbrake_on}, 4'b0110);
      rearm();
   endtask

   task automatic s_modes();
      logic [2:0] md [4];
      md = '{3'h0, MODE_TORQUE, MODE_TQ_CONT, MODE_PRESSURE};
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, ADDR_CTRL, (i == 0) ? 32'h80 : 32'h82);
         ctrl_mode <= md[i];
         fire(2'h0, 1'b0, 2'b01, 32'h30 + i);
         chk({base_on, dbrake_on}, 4'b1001);
         rearm();
      end
   endtask

   task automatic s_cyc();
      @(posedge pclk);
      ctrl_mode <= MODE_CYC_SYNC;
      fire(2'h1, 1'b0, 2'b01, 32'h14);
      chk(cmd_accept, 2'b10);
      rearm();
      chk(cmd_accept, 2'b11);
   endtask

   task automatic s_coast();
      apb(1'b1, ADDR_CTRL, 32'h02);
      ctrl_mode <= 3'h0;
      fire(2'h1, 1'b0, 2'b01, 32'h15);
      chk({base_on, dbrake_on, edbrake_on}, 6'b100000);
      rearm();
   endtask

   task automatic s_netloss();
      apb(1'b1, ADDR_CTRL, 32'h180);
      netloss <= 1'b1;
      wait_n(4);
      chk({dbrake_on, fault_output}, 4'b1100);
      @(posedge pclk);
      netloss <= 1'b0;
      rearm();
   endtask

   task automatic s_hist();
      apb(1'b1, ADDR_CTRL, 32'h82);
      apb(1'b1, ADDR_HCLEAR, {16'h0, HCLEAR_KEY});
      for (int k = 1; k <= 17; k++) fire(2'h1, 1'b0, 2'b01, k);
      rd(ADDR_HCOUNT, 32'd16);
      rd(ADDR_HIST, 32'd17);
      rd(ADDR_HIST + 12'h078, 32'd2);
      apb(1'b0, ADDR_HIST + 12'h004, 32'h0);
      t_new = rdat;
      apb(1'b0, ADDR_HIST_END, 32'h0);
      chk(t_new > rdat, 1'b1);
      for (int w = 0; w < 4; w++) begin
         fire(2'h1, 1'b0, 2'b01, 32'h40 + w);
         @(posedge pclk);
         tool_clear <= (w == 0);
         transient_clear <= (w == 1);
         @(posedge pclk);
         tool_clear <= 1'b0;
         transient_clear <= 1'b0;
         if (w == 2) apb(1'b1, ADDR_CTRL, 32'h22);
         if (w == 3) apb(1'b1, ADDR_HCLEAR, {16'h0, HCLEAR_KEY});
         rd(ADDR_HCOUNT, 32'd0);
      end
      rearm();
   endtask

   task automatic give_verdict();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      give_verdict();
   end

   // Main sequence
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      s_regs();
      s_ramp();
      s_dbrake();
      s_edb();
      s_modes();
      s_cyc();
      s_coast();
      s_netloss();
      s_hist();
      give_verdict();
   end
endmodule
